// ---- ioexp_params.svh ----
// timing-free constants of the sixteen-line serial port expander
// assumes inclusion by bare name from the expander's design files
`ifndef IOEXP_PARAMS_SVH
`define IOEXP_PARAMS_SVH

// upper four bits of the seven-bit slave address; straps fill the rest
`define IOX_ADDR_FIXED 4'h4

// register groups, selected by pointer bits [2:1]; bit 0 picks the byte
`define IOX_GRP_IN 2'h0
`define IOX_GRP_OUT 2'h1
`define IOX_GRP_POL 2'h2
`define IOX_GRP_DIR 2'h3

// reset values: all lines inputs, outputs latched high, no inversion
`define IOX_RST_DIR 16'hffff
`define IOX_RST_OUT 16'hffff
`define IOX_RST_POL 16'h0000
`define IOX_RST_IN 16'h0000

// bit counter: eight data bits, then the acknowledge bit
`define IOX_ACK_BIT 4'h8
`define IOX_LAST_DATA_BIT 4'h7

`endif

// ---- ioexp_pkg.sv ----
// types shared by the expander's serial engine
// assumes nothing of its surroundings
package ioexp_pkg;

  // transfer phase of the slave engine
  typedef enum logic [2:0]
  {
    st_idle,
    st_addr,
    st_cmd,
    st_wdata,
    st_rdata,
    st_ignore
  } link_state_t;

endpackage : ioexp_pkg

// ---- ioexp_sync.sv ----
// two-flop synchroniser for a vector of independent levels
// assumes each bit is a level that stays put for several sys_clk cycles
`timescale 1ns/100ps
`default_nettype none

module ioexp_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // meta is read by sync_out only
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : ioexp_sync

`default_nettype wire

// ---- ioexp_scl_capture.sv ----
// serial data capture running on the bus clock itself
// assumes scl_clk is the raw serial clock pin and may stop between frames
`timescale 1ns/100ps
`default_nettype none

module ioexp_scl_capture
(
  input wire logic scl_clk,
  input wire logic rstn,
  input wire logic sda_in,
  output logic rx_bit,
  output logic rx_tog
);

  // data is sampled on the rising clock edge, where the bus guarantees
  // it stable; the toggle tells the system domain a new bit is here
  always_ff @(posedge scl_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_bit <= 1'b0;
      rx_tog <= 1'b0;
    end
    else
    begin
      rx_bit <= sda_in;
      rx_tog <= ~rx_tog;
    end
  end

endmodule : ioexp_scl_capture

`default_nettype wire

// ---- i2c_remote_io_expander_16bit.sv ----
// sixteen-line remote i/o expander behind a two-wire serial slave
// assumes pull-ups on the data and interrupt wires outside, a bus
// clock on scl_clk that may stop, and rstn as the power-on reset
`timescale 1ns/100ps
`default_nettype none

`include "ioexp_params.svh"

// How it works
// - direction, input, output and polarity each held as two 8-bit bytes.
// - reset leaves every line configured as an input.
// - master writes direction bits; set bit means input, clear means output.
// - input register keeps sampled line values, output register drives lines.
// - set polarity bit inverts that line's value seen in the input register.
// - every register, including direction, output and polarity, reads back.
// - power-on reset restores register defaults and restarts the serial engine.
// - interrupt asserts while any input line differs from its input register.
// - interrupt pin is open-drain, pulled low only while asserted.
// - three address straps fill low slave address bits, eight devices share.
// - output values stay latched until rewritten or reset.
module i2c_remote_io_expander_16bit
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_strap_0,
  input wire logic addr_strap_1,
  input wire logic addr_strap_2,
  input wire logic [15:0] port_in,
  output logic [15:0] port_out,
  output logic [15:0] port_oe,
  output logic int_n_out,
  output logic int_n_oe
);

  // ****************************************************************
  // link capture and synchronisation
  // ****************************************************************
  logic rx_bit;
  logic rx_tog;
  logic [21:0] sync_raw;
  logic [21:0] sync_q;

  ioexp_scl_capture u_capture
  (
    .scl_clk(scl_clk),
    .rstn(rstn),
    .sda_in(sda_in),
    .rx_bit(rx_bit),
    .rx_tog(rx_tog)
  );

  assign sync_raw = {rx_tog, scl_clk, sda_in, addr_strap_2, addr_strap_1,
                     addr_strap_0, port_in};

  ioexp_sync #(.WIDTH(22)) u_sync
  (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(sync_raw),
    .sync_out(sync_q)
  );

  wire tog_s = sync_q[21];
  wire scl_s = sync_q[20];
  wire sda_s = sync_q[19];
  wire [2:0] strap_s = sync_q[18:16];
  wire [15:0] pins_s = sync_q[15:0];

  // ****************************************************************
  // bus condition detection
  // ****************************************************************
  logic scl_d;
  logic sda_d;
  logic tog_d;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      tog_d <= 1'b0;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      tog_d <= tog_s;
    end
  end

  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire scl_fall = scl_d & ~scl_s;
  wire bit_ev = tog_s ^ tog_d;
  // rx_bit settles on the same bus edge as its toggle, two sys_clk cycles before the toggle shows here, and
  // holds until the next rising edge, so it is read as a quiet level
  wire bit_val = rx_bit;

  // ****************************************************************
  // register file
  // ****************************************************************
  logic [15:0] dir_reg;
  logic [15:0] out_reg;
  logic [15:0] pol_reg;
  logic [15:0] in_reg;
  logic primed;
  logic [1:0] warm;

  wire [15:0] live_in = pins_s ^ pol_reg;

  // ****************************************************************
  // serial engine state
  // ****************************************************************
  ioexp_pkg::link_state_t state;
  ioexp_pkg::link_state_t next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [2:0] ptr;
  logic [2:0] next_ptr;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic next_sda_oe;
  logic wr_en;
  logic load_en;

  wire [6:0] my_addr = {`IOX_ADDR_FIXED, strap_s};
  wire addr_hit = (shift[7:1] == my_addr);

  // the byte sent on a read: first from the command pointer, then from
  // its pair partner after each acknowledged byte
  wire [2:0] sel_ptr = (state == ioexp_pkg::st_rdata) ? {ptr[2:1], ~ptr[0]}
                                                      : ptr;
  wire sel_hi = sel_ptr[0];
  wire [1:0] sel_grp = sel_ptr[2:1];
  wire [7:0] live_byte = sel_hi ? live_in[15:8] : live_in[7:0];
  wire [7:0] out_byte = sel_hi ? out_reg[15:8] : out_reg[7:0];
  wire [7:0] pol_byte = sel_hi ? pol_reg[15:8] : pol_reg[7:0];
  wire [7:0] dir_byte = sel_hi ? dir_reg[15:8] : dir_reg[7:0];
  wire [7:0] rd_byte = (sel_grp == `IOX_GRP_IN) ? live_byte :
                       (sel_grp == `IOX_GRP_OUT) ? out_byte :
                       (sel_grp == `IOX_GRP_POL) ? pol_byte : dir_byte;
  wire rd_is_in = (sel_grp == `IOX_GRP_IN);

  // drive-low request for the data bit on the wire during a read
  wire [2:0] tx_idx = 3'(`IOX_LAST_DATA_BIT - bit_cnt);
  wire tx_low = ~tx[tx_idx];

  always_comb
  begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_ptr = ptr;
    next_tx = tx;
    next_sda_oe = sda_oe;
    wr_en = 1'b0;
    load_en = 1'b0;
    if (start_det)
    begin
      // a repeated start also lands here and keeps the pointer
      next_state = ioexp_pkg::st_addr;
      next_bit_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end
    else if (stop_det)
    begin
      next_state = ioexp_pkg::st_idle;
      next_bit_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end
    else if (bit_ev && state != ioexp_pkg::st_idle
             && state != ioexp_pkg::st_ignore)
    begin
      if (bit_cnt == `IOX_ACK_BIT)
      begin
        next_bit_cnt = 4'h0;
        if (state == ioexp_pkg::st_rdata)
        begin
          if (bit_val)
          begin
            // master declined more data: let go until the next start
            next_state = ioexp_pkg::st_ignore;
          end
          else
          begin
            next_ptr = sel_ptr;
            next_tx = rd_byte;
            load_en = 1'b1;
          end
        end
      end
      else
      begin
        next_shift = {shift[6:0], bit_val};
        next_bit_cnt = bit_cnt + 4'h1;
      end
    end
    else if (scl_fall)
    begin
      unique case (state)
        ioexp_pkg::st_addr:
        begin
          if (bit_cnt == `IOX_ACK_BIT)
          begin
            if (addr_hit)
            begin
              next_sda_oe = 1'b1;
              if (shift[0])
              begin
                // pre-flipped: the acknowledge edge flips back, loads byte one
                next_state = ioexp_pkg::st_rdata;
                next_ptr = {ptr[2:1], ~ptr[0]};
              end
              else
              begin
                next_state = ioexp_pkg::st_cmd;
              end
            end
            else
            begin
              next_state = ioexp_pkg::st_ignore;
              next_sda_oe = 1'b0;
            end
          end
        end
        ioexp_pkg::st_cmd:
        begin
          if (bit_cnt == `IOX_ACK_BIT)
          begin
            next_ptr = shift[2:0];
            next_state = ioexp_pkg::st_wdata;
          end
          next_sda_oe = (bit_cnt == `IOX_ACK_BIT);
        end
        ioexp_pkg::st_wdata:
        begin
          if (bit_cnt == `IOX_ACK_BIT)
          begin
            wr_en = 1'b1;
            next_ptr = {ptr[2:1], ~ptr[0]};
          end
          next_sda_oe = (bit_cnt == `IOX_ACK_BIT);
        end
        ioexp_pkg::st_rdata:
        begin
          // release during the master's acknowledge bit
          next_sda_oe = (bit_cnt == `IOX_ACK_BIT) ? 1'b0 : tx_low;
        end
        ioexp_pkg::st_idle,
        ioexp_pkg::st_ignore:
        begin
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ioexp_pkg::st_idle;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      ptr <= 3'h0;
      tx <= 8'hff;
      sda_oe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      ptr <= next_ptr;
      tx <= next_tx;
      sda_oe <= next_sda_oe;
    end
  end

  // ****************************************************************
  // register writes and input capture
  // ****************************************************************
  // after a data byte the pointer flips to the other byte of the pair,
  // so a two-byte write fills both halves of one register
  wire [1:0] wr_grp = ptr[2:1];
  wire [3:0] wr_base = {ptr[0], 3'h0};
  wire wr_out = wr_en && wr_grp == `IOX_GRP_OUT;
  wire wr_pol = wr_en && wr_grp == `IOX_GRP_POL;
  wire wr_dir = wr_en && wr_grp == `IOX_GRP_DIR;
  wire cap_in = load_en && rd_is_in;
  wire [3:0] cap_base = {sel_hi, 3'h0};

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dir_reg <= `IOX_RST_DIR;
      out_reg <= `IOX_RST_OUT;
      pol_reg <= `IOX_RST_POL;
    end
    else
    begin
      if (wr_dir)
      begin
        dir_reg[wr_base +: 8] <= shift;
      end
      if (wr_out)
      begin
        out_reg[wr_base +: 8] <= shift;
      end
      if (wr_pol)
      begin
        pol_reg[wr_base +: 8] <= shift;
      end
    end
  end

  // the input register is a snapshot: taken once after reset and again
  // for each input-register byte the master reads, which is what clears the interrupt
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      in_reg <= `IOX_RST_IN;
      warm <= 2'h0;
      primed <= 1'b0;
    end
    else
    begin
      // pin synchronisers leave reset at zero: wait for the real levels
      warm <= {warm[0], 1'b1};
      primed <= warm[1];
      if (!primed)
      begin
        in_reg <= live_in;
      end
      else if (cap_in)
      begin
        in_reg[cap_base +: 8] <= live_byte;
      end
    end
  end

  // ****************************************************************
  // pins
  // ****************************************************************
  // only lines configured as inputs can raise the interrupt; a line
  // that returns to its captured value drops it again by itself
  wire [15:0] in_diff = (live_in ^ in_reg) & dir_reg;
  logic int_act;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      int_act <= 1'b0;
    end
    else
    begin
      int_act <= primed && (|in_diff);
    end
  end

  assign port_out = out_reg;
  assign port_oe = ~dir_reg;
  assign int_n_out = 1'b0;
  assign int_n_oe = int_act;
  assign sda_out = 1'b0;

endmodule : i2c_remote_io_expander_16bit

`default_nettype wire

// ---- ioexp_props.sv ----
// pin-level assertions for the port expander, sampled on sys_clk
// assumes serial clock phases of many sys_clk cycles
`timescale 1ns/100ps
`default_nettype none
module ioexp_props
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl_clk,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [15:0] port_out,
  input wire logic [15:0] port_oe,
  input wire logic int_n_out,
  input wire logic int_n_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_scl_high;
    scl_clk [*6];
  endsequence
  sequence s_int_quiet;
    !int_n_oe ##1 !int_n_oe;
  endsequence
  property p_drain;
    sda_out == 1'b0 && int_n_out == 1'b0;
  endproperty
  a_drain: assert property (p_drain) else $error("pin driven high");
  property p_rst;
    $rose(rstn) |-> port_oe == 16'h0000 && port_out == 16'hffff && !sda_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_int_start;
    $rose(rstn) |-> s_int_quiet;
  endproperty
  a_int_start: assert property (p_int_start) else $error("early int");
  property p_out;
    $changed(port_out) |-> !scl_clk;
  endproperty
  a_out: assert property (p_out) else $error("output moved");
  property p_dir;
    $changed(port_oe) |-> !scl_clk;
  endproperty
  a_dir: assert property (p_dir) else $error("direction moved");
  property p_ack;
    $rose(sda_oe) |-> !scl_clk;
  endproperty
  a_ack: assert property (p_ack) else $error("data pulled in high");
  property p_stand;
    s_scl_high |-> $stable(sda_oe);
  endproperty
  a_stand: assert property (p_stand) else $error("data moved");
  property p_bound;
    $rose(sda_oe) |-> ##[1:400] !sda_oe;
  endproperty
  a_bound: assert property (p_bound) else $error("data held");
endmodule : ioexp_props
bind i2c_remote_io_expander_16bit ioexp_props u_props
(
  .sys_clk(sys_clk), .rstn(rstn), .scl_clk(scl_clk), .sda_out(sda_out),
  .sda_oe(sda_oe), .port_out(port_out), .port_oe(port_oe),
  .int_n_out(int_n_out), .int_n_oe(int_n_oe)
);
`default_nettype wire

// ---- ioexp_master_model.sv ----
// serial bus master model: start, stop and byte transfers
// assumes the data wire is resolved outside with a pull-up
`timescale 1ns/100ps
`default_nettype none
module ioexp_master_model
(
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  // clock idles high; timing runs free of sys_clk so the phase drifts
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic start;
    #83 sda_oe = 1'b0;
    #83 scl = 1'b1;
    #83 sda_oe = 1'b1;
    #83 scl = 1'b0;
  endtask : start
  task automatic stop;
    #83 sda_oe = 1'b1;
    #83 scl = 1'b1;
    #83 sda_oe = 1'b0;
    #83;
  endtask : stop
  task automatic bit_x(input logic b, output logic r);
    #83 sda_oe = ~b;
    #83 scl = 1'b1;
    #83 r = sda;
    scl = 1'b0;
  endtask : bit_x
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask : rbyte
endmodule : ioexp_master_model
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the port expander
// assumes the master model and the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "ioexp_params.svh"
module tb_top;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] strap = 3'h0;
  logic [15:0] ext_in = 16'h0000;
  logic scl, m_oe, sda_oe, sda_out, int_n_out, int_n_oe, ack;
  logic [15:0] port_out, port_oe, pins, rd;
  int num_errors = 0;
  int cmp_count = 0;
  wire sda = ~(sda_oe | m_oe);
  // driven lines show the output latch on the pin
  assign pins = (port_oe & port_out) | (~port_oe & ext_in);
  always #4 sys_clk = ~sys_clk;
  ioexp_master_model mdl(.sda(sda), .scl(scl), .sda_oe(m_oe));
  i2c_remote_io_expander_16bit dut
  (
    .sys_clk(sys_clk), .rstn(rstn), .scl_clk(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_0(strap[0]),
    .addr_strap_1(strap[1]), .addr_strap_2(strap[2]), .port_in(pins),
    .port_out(port_out), .port_oe(port_oe), .int_n_out(int_n_out),
    .int_n_oe(int_n_oe)
  );
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic adr(input logic rw);
    mdl.start();
    mdl.wbyte({`IOX_ADDR_FIXED, strap, rw}, ack);
    chk(ack, 1'b1);
  endtask : adr
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    adr(1'b0);
    mdl.wbyte(cmd, ack);
    mdl.wbyte(d[7:0], ack);
    mdl.wbyte(d[15:8], ack);
    mdl.stop();
  endtask : wr
  task automatic rchk(input logic [7:0] cmd, input logic [15:0] exp);
    adr(1'b0);
    mdl.wbyte(cmd, ack);
    adr(1'b1);
    mdl.rbyte(1'b0, rd[7:0]);
    mdl.rbyte(1'b1, rd[15:8]);
    mdl.stop();
    chk(rd, exp);
  endtask : rchk
  task automatic settle(input logic [15:0] v);
    @(negedge sys_clk) ext_in = v;
    repeat (12) @(negedge sys_clk);
  endtask : settle
  task automatic print_verdict;
    $display("compares=%0d errors=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    // the tests need about 175 us; allow a margin well under 100k cycles
    #400us;
    num_errors++;
    print_verdict();
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) rstn = 1'b1;
    settle(16'h0000);
    chk(port_oe, 16'h0000);
    chk(port_out, 16'hffff);
    rchk(8'h06, 16'hffff);
    rchk(8'h04, 16'h0000);
    $display("test reset done");
    for (int k = 0; k < 8; k++)
    begin
      @(negedge sys_clk) strap = k[2:0];
      settle(16'h0000);
      adr(1'b0);
      mdl.stop();
      mdl.start();
      mdl.wbyte({`IOX_ADDR_FIXED, ~strap, 1'b0}, ack);
      chk(ack, 1'b0);
      mdl.stop();
    end
    $display("test address done");
    wr(8'h02, 16'h1234);
    wr(8'h06, 16'hff00);
    settle(16'h0000);
    chk(port_oe, 16'h00ff);
    chk(port_out, 16'h1234);
    wr(8'h00, 16'h5a5a);
    rchk(8'h02, 16'h1234);
    rchk(8'h06, 16'hff00);
    $display("test direction done");
    settle(16'hc3a5);
    wr(8'h04, 16'hf0f0);
    rchk(8'h00, 16'h33c4);
    settle(16'hc3ff);
    chk(int_n_oe, 1'b0);
    settle(16'h43ff);
    chk(int_n_oe, 1'b1);
    settle(16'hc3ff);
    chk(int_n_oe, 1'b0);
    settle(16'h43ff);
    rchk(8'h00, 16'hb3c4);
    settle(16'h43ff);
    chk(int_n_oe, 1'b0);
    $display("test input done");
    adr(1'b0);
    @(negedge sys_clk) rstn = 1'b0;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    mdl.stop();
    settle(16'h43ff);
    chk(port_out, 16'hffff);
    chk(port_oe, 16'h0000);
    chk(int_n_oe, 1'b0);
    rchk(8'h04, 16'h0000);
    $display("test reset again done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
